/* rtl/prog_entry_pkg.sv */
/*
  Constants and carrier types for the flash programming entry block.
  Assumes a single 25 MHz clock and a synchronous, active-low reset.
*/
`default_nettype none

package prog_entry_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned RATE_1M = 1_000_000;
  localparam int unsigned RATE_500K = 500_000;
  localparam int unsigned RATE_250K = 250_000;
  localparam int unsigned RATE_115K2 = 115_200;
  localparam int unsigned INIT_WINDOW_MS = 100;
  localparam int unsigned INIT_WINDOW_CYC = CLK_HZ / 1000 * INIT_WINDOW_MS;
  localparam int unsigned DIV_W = 8;
  // bit periods in clocks, rounded down
  localparam logic [DIV_W-1:0] DIV_1M = DIV_W'(CLK_HZ / RATE_1M);
  localparam logic [DIV_W-1:0] DIV_500K = DIV_W'(CLK_HZ / RATE_500K);
  localparam logic [DIV_W-1:0] DIV_250K = DIV_W'(CLK_HZ / RATE_250K);
  localparam logic [DIV_W-1:0] DIV_115K2 = DIV_W'(CLK_HZ / RATE_115K2);
  localparam logic [1:0] RATE_SEL_RESET = 2'h3;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] FRAME_BITS = 4'ha;
  localparam logic SHARED_PIN_RESET_OE = 1'b0;
  localparam logic SHARED_PIN_RESET_OUT = 1'b0;

  typedef enum logic [2:0]
  {
    MODE_HOLD = 3'h1,
    MODE_NORMAL = 3'h2,
    MODE_PROG = 3'h4
  } mode_e;

  typedef struct packed
  {
    logic valid;
    logic [7:0] data;
    logic frame_err;
  } rx_char_s;

endpackage : prog_entry_pkg

`default_nettype wire

/* rtl/serial_char_engine.sv */
/*
  Half-duplex 8N1 character engine: one receiver and one transmitter
  sharing a bit period. Assumes rx_line is already synchronised.
*/
`default_nettype none

module serial_char_engine
  import prog_entry_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [DIV_W-1:0] bit_div,
  input wire logic rx_line,
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  output logic tx_line,
  output logic tx_busy,
  output rx_char_s rx_char
);

  //----------------------------------------
  // receiver
  //----------------------------------------
  logic rx_busy_q, rx_busy_d;
  logic [DIV_W-1:0] rx_cnt_q, rx_cnt_d;
  logic [3:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  rx_char_s rx_char_q, rx_char_d;

  always_comb
  begin
    rx_busy_d = rx_busy_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_char_d = '0;
    if (!rx_busy_q)
    begin
      if (!rx_line)
      begin
        // start edge: aim at mid-bit
        rx_busy_d = 1'b1;
        rx_cnt_d = bit_div >> 1;
        rx_bit_d = 4'h0;
      end
    end
    else if (rx_cnt_q != '0)
    begin
      rx_cnt_d = rx_cnt_q - 1'b1;
    end
    else
    begin
      rx_cnt_d = bit_div - 1'b1;
      rx_bit_d = rx_bit_q + 1'b1;
      if (rx_bit_q == 4'h0 && rx_line)
      begin
        rx_busy_d = 1'b0; // glitch, not a start bit
      end
      else if (rx_bit_q >= 4'h1 && rx_bit_q <= DATA_BITS)
      begin
        rx_sh_d = {rx_line, rx_sh_q[7:1]}; // lsb first
      end
      else if (rx_bit_q == FRAME_BITS - 1'b1)
      begin
        rx_busy_d = 1'b0;
        rx_char_d.valid = 1'b1;
        rx_char_d.data = rx_sh_q;
        rx_char_d.frame_err = !rx_line; // stop bit must be high
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= '0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_char_q <= '0;
    end
    else
    begin
      rx_busy_q <= rx_busy_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_char_q <= rx_char_d;
    end
  end

  assign rx_char = rx_char_q;

  //----------------------------------------
  // transmitter
  //----------------------------------------
  logic tx_busy_q, tx_busy_d;
  logic [DIV_W-1:0] tx_cnt_q, tx_cnt_d;
  logic [3:0] tx_bit_q, tx_bit_d;
  logic [9:0] tx_sh_q, tx_sh_d;

  always_comb
  begin
    tx_busy_d = tx_busy_q;
    tx_cnt_d = tx_cnt_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    if (!tx_busy_q)
    begin
      if (tx_start)
      begin
        tx_busy_d = 1'b1;
        tx_sh_d = {1'b1, tx_data, 1'b0}; // stop, data, start
        tx_cnt_d = bit_div - 1'b1;
        tx_bit_d = 4'h0;
      end
    end
    else if (tx_cnt_q != '0)
    begin
      tx_cnt_d = tx_cnt_q - 1'b1;
    end
    else
    begin
      tx_cnt_d = bit_div - 1'b1;
      tx_sh_d = {1'b1, tx_sh_q[9:1]};
      tx_bit_d = tx_bit_q + 1'b1;
      if (tx_bit_q == FRAME_BITS - 1'b1)
      begin
        tx_busy_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= '0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 10'h3ff;
    end
    else
    begin
      tx_busy_q <= tx_busy_d;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
    end
  end

  // idle is high when nothing is being sent
  assign tx_line = tx_busy_q ? tx_sh_q[0] : 1'b1;
  assign tx_busy = tx_busy_q;

endmodule : serial_char_engine

`default_nettype wire

/* rtl/serial_flash_program_entry.sv */
/*
  Programming-mode entry and serial link front end of the device.
  Assumes clk is the internal fast oscillator and that the command
  layer above consumes received characters and supplies replies.
*/
`default_nettype none

module serial_flash_program_entry
  import prog_entry_pkg::*;
#(
  parameter int unsigned INIT_CYC = INIT_WINDOW_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mode_serial_pin_in,
  output logic mode_serial_pin_out,
  output logic mode_serial_pin_oe,
  input wire logic prog_receive_pin,
  output logic prog_transmit_pin,
  input wire logic [1:0] rate_sel,
  input wire logic rate_load,
  input wire logic reply_valid,
  input wire logic [7:0] reply_data,
  output logic reply_ready,
  output logic prog_mode,
  output logic normal_mode,
  output logic init_timeout,
  output logic fast_clock_select,
  output logic shared_port_pin_oe,
  output logic shared_port_pin_out,
  output rx_char_s rx_out
);

  //----------------------------------------
  // pin synchronisers
  //----------------------------------------
  logic mode_s1_q, mode_s2_q;
  logic rxd_s1_q, rxd_s2_q;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      mode_s1_q <= 1'b1;
      mode_s2_q <= 1'b1;
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
    end
    else
    begin
      mode_s1_q <= mode_serial_pin_in;
      mode_s2_q <= mode_s1_q;
      rxd_s1_q <= prog_receive_pin;
      rxd_s2_q <= rxd_s1_q;
    end
  end

  //----------------------------------------
  // mode latch at reset release
  //----------------------------------------
  // two cycles of hold let the synchroniser show the post-release level
  mode_e mode_q, mode_d;
  logic [1:0] settle_q, settle_d;
  logic [31:0] init_cnt_q, init_cnt_d;
  logic init_to_q, init_to_d;
  logic got_char_q, got_char_d;
  logic [1:0] rate_q, rate_d;
  rx_char_s rx_char;

  always_comb
  begin
    mode_d = mode_q;
    settle_d = settle_q;
    case (mode_q)
      MODE_HOLD:
      begin
        if (settle_q != 2'h2)
        begin
          settle_d = settle_q + 1'b1;
        end
        else
        begin
          // low selects programming, high selects normal
          mode_d = mode_s2_q ? MODE_NORMAL : MODE_PROG;
        end
      end
      MODE_NORMAL:
      begin
        mode_d = MODE_NORMAL;
      end
      MODE_PROG:
      begin
        mode_d = MODE_PROG; // left only by the next reset
      end
      default:
      begin
        mode_d = MODE_HOLD;
      end
    endcase
  end

  // the host owes its settings within the window; we only flag lateness
  always_comb
  begin
    init_cnt_d = init_cnt_q;
    init_to_d = init_to_q;
    got_char_d = got_char_q | (rx_char.valid & (mode_q == MODE_PROG));
    rate_d = rate_q;
    if (mode_q == MODE_PROG && !got_char_q && !init_to_q)
    begin
      if (init_cnt_q >= INIT_CYC - 1)
      begin
        init_to_d = 1'b1;
      end
      else
      begin
        init_cnt_d = init_cnt_q + 32'h1;
      end
    end
    if (rate_load && mode_q == MODE_PROG)
    begin
      rate_d = rate_sel;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      mode_q <= MODE_HOLD;
      settle_q <= 2'h0;
      init_cnt_q <= 32'h0;
      init_to_q <= 1'b0;
      got_char_q <= 1'b0;
      rate_q <= RATE_SEL_RESET;
    end
    else
    begin
      mode_q <= mode_d;
      settle_q <= settle_d;
      init_cnt_q <= init_cnt_d;
      init_to_q <= init_to_d;
      got_char_q <= got_char_d;
      rate_q <= rate_d;
    end
  end

  //----------------------------------------
  // bit rate and character engine
  //----------------------------------------
  logic [DIV_W-1:0] bit_div;
  always_comb
  begin
    case (rate_q)
      2'h0: bit_div = DIV_1M;
      2'h1: bit_div = DIV_500K;
      2'h2: bit_div = DIV_250K;
      default: bit_div = DIV_115K2;
    endcase
  end

  logic tx_line, tx_busy, line_rx;
  logic in_prog;
  assign in_prog = (mode_q == MODE_PROG);
  // one-wire line and dedicated receive pin both feed the receiver
  // hazard: the shared line hears our own echo, so it is muted while sending
  assign line_rx = in_prog & (tx_busy | (mode_s2_q & rxd_s2_q)) | !in_prog;

  logic tx_start;
  assign tx_start = in_prog & reply_valid & !tx_busy;

  serial_char_engine u_engine
  (
    .clk(clk),
    .reset_n(reset_n),
    .bit_div(bit_div),
    .rx_line(line_rx),
    .tx_start(tx_start),
    .tx_data(reply_data),
    .tx_line(tx_line),
    .tx_busy(tx_busy),
    .rx_char(rx_char)
  );

  //----------------------------------------
  // registered outputs
  //----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      mode_serial_pin_out <= 1'b1;
      mode_serial_pin_oe <= 1'b0;
      prog_transmit_pin <= 1'b1;
      reply_ready <= 1'b0;
      prog_mode <= 1'b0;
      normal_mode <= 1'b0;
      init_timeout <= 1'b0;
      fast_clock_select <= 1'b1;
      shared_port_pin_oe <= SHARED_PIN_RESET_OE;
      shared_port_pin_out <= SHARED_PIN_RESET_OUT;
      rx_out <= '0;
    end
    else
    begin
      // drive only while a low bit goes out, else release to pull-up
      mode_serial_pin_out <= 1'b0;
      mode_serial_pin_oe <= in_prog & tx_busy & !tx_line;
      prog_transmit_pin <= in_prog ? tx_line : 1'b1;
      reply_ready <= tx_start;
      prog_mode <= in_prog;
      normal_mode <= (mode_q == MODE_NORMAL);
      init_timeout <= init_to_q;
      fast_clock_select <= in_prog | (mode_q == MODE_HOLD);
      // unused pins stay at their reset state while programming
      shared_port_pin_oe <= SHARED_PIN_RESET_OE;
      shared_port_pin_out <= SHARED_PIN_RESET_OUT;
      rx_out <= in_prog ? rx_char : '0;
    end
  end

  //----------------------------------------
  // checks
  //----------------------------------------
  a_mode_low_prog: assert property (@(posedge clk) disable iff (!reset_n)
    (mode_q == MODE_HOLD && settle_q == 2'h2 && !mode_s2_q) |=> mode_q == MODE_PROG)
    else $error("low mode pin did not select programming");
  a_mode_high_norm: assert property (@(posedge clk) disable iff (!reset_n)
    (mode_q == MODE_HOLD && settle_q == 2'h2 && mode_s2_q) |=> ##1 normal_mode)
    else $error("high mode pin did not select normal mode");
  a_mode_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    prog_mode |=> prog_mode)
    else $error("programming mode dropped without reset");
  a_port_reset_state: assert property (@(posedge clk) disable iff (!reset_n)
    prog_mode |-> (shared_port_pin_oe == SHARED_PIN_RESET_OE
      && shared_port_pin_out == SHARED_PIN_RESET_OUT))
    else $error("unused pin left reset state");
  a_fast_clock_prog: assert property (@(posedge clk) disable iff (!reset_n)
    prog_mode |-> fast_clock_select)
    else $error("fast oscillator not selected in programming");
  a_line_release: assert property (@(posedge clk) disable iff (!reset_n)
    (!tx_busy ##1 !tx_busy) |=> !mode_serial_pin_oe)
    else $error("one-wire line driven while idle");
  a_tx_idle_high: assert property (@(posedge clk) disable iff (!reset_n)
    $past(!tx_busy) |-> prog_transmit_pin)
    else $error("transmit pin not idle high");
  a_start_bit_low: assert property (@(posedge clk) disable iff (!reset_n)
    tx_start |=> ##1 (!prog_transmit_pin && mode_serial_pin_oe))
    else $error("start bit missing on link pins");
  a_rate_fixed_norm: assert property (@(posedge clk) disable iff (!reset_n)
    normal_mode |-> rate_q == RATE_SEL_RESET)
    else $error("bit rate changed outside programming");

endmodule : serial_flash_program_entry

`default_nettype wire

/* dv/host_link_model.sv */
/*
  Behavioural programmer on the far side of the link: 8n1 sender and receiver.
  Assumes the bench wires host_low into the pulled-up mode pin.
*/
`default_nettype none

module host_link_model
(
  input wire logic clk,
  input wire logic mode_line,
  input wire logic dev_tx,
  output logic host_low,
  output logic host_tx
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    host_low = 1'b0;
    host_tx = 1'b1;
  end

  // ----------------------------------------
  // character send and receive
  // ----------------------------------------
  task automatic hold_low(input logic v);
    host_low = v;
  endtask : hold_low

  task automatic send(input logic [7:0] b, input int div, input logic stop, input logic one_wire);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk);
      host_low = one_wire & ~f[i];
      host_tx = one_wire | f[i];
      repeat (div - 1) @(negedge clk);
    end
    @(negedge clk);
    // let go so the pull-up returns the line high
    host_low = 1'b0;
    host_tx = 1'b1;
  endtask : send

  task automatic recv(input int div, input logic one_wire, output logic [7:0] b, output logic ok);
    int n;
    b = 8'h00;
    // sample between edges so registered pins are settled
    for (n = 0; n < 20 * div; n++)
    begin
      @(negedge clk);
      if ((one_wire ? mode_line : dev_tx) === 1'b0)
        break;
    end
    ok = (n < 20 * div);
    repeat (div / 2) @(negedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (div) @(negedge clk);
      b[i] = one_wire ? mode_line : dev_tx;
    end
    repeat (div) @(negedge clk);
    ok = ok & ((one_wire ? mode_line : dev_tx) === 1'b1);
  endtask : recv
endmodule : host_link_model

`default_nettype wire

/* dv/test_serial_flash_program_entry.sv */
/*
  Self-checking bench for the programming entry block.
  Assumes a 25 MHz clock and an outside pull-up on the mode pin.
*/
`default_nettype none

module test_serial_flash_program_entry;
  import prog_entry_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned INIT_SIM = 200;
  localparam int RATES [4] = '{RATE_1M, RATE_500K, RATE_250K, RATE_115K2};
  logic clk, reset_n, mode_line, oe, pout, rx_pin, tx_pin, rate_load, reply_valid, reply_ready;
  logic prog_mode, normal_mode, init_timeout, fast_clock_select, sp_oe, sp_out, host_low;
  logic [1:0] rate_sel;
  logic [7:0] reply_data;
  rx_char_s rx_out;
  logic [31:0] seed, v;
  logic [7:0] exp_q [$];
  int n_mismatch, checks, div;

  assign mode_line = ~(oe & ~pout) & ~host_low;

  serial_flash_program_entry #(.INIT_CYC(INIT_SIM)) dut (.clk(clk), .reset_n(reset_n),
    .mode_serial_pin_in(mode_line), .mode_serial_pin_out(pout), .mode_serial_pin_oe(oe),
    .prog_receive_pin(rx_pin), .prog_transmit_pin(tx_pin), .rate_sel(rate_sel),
    .rate_load(rate_load), .reply_valid(reply_valid), .reply_data(reply_data),
    .reply_ready(reply_ready), .prog_mode(prog_mode), .normal_mode(normal_mode),
    .init_timeout(init_timeout), .fast_clock_select(fast_clock_select),
    .shared_port_pin_oe(sp_oe), .shared_port_pin_out(sp_out), .rx_out(rx_out));

  host_link_model host (.clk(clk), .mode_line(mode_line), .dev_tx(tx_pin),
    .host_low(host_low), .host_tx(rx_pin));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic do_reset(input logic low);
    @(negedge clk);
    reset_n = 1'b0;
    host.hold_low(low);
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
    host.hold_low(1'b0);
    chk("prog_mode", {31'h0, low}, {31'h0, prog_mode});
    chk("normal_mode", {31'h0, ~low}, {31'h0, normal_mode});
  endtask : do_reset

  task automatic wait_rx(input int d, input logic ferr);
    int n;
    for (n = 0; n < 12 * d; n++)
    begin
      @(negedge clk);
      if (rx_out.valid === 1'b1)
        break;
    end
    if (n == 12 * d)
    begin
      chk("rx_timeout", 1, 0);
      close_out();
    end
    chk("rx_data", {24'h0, exp_q.pop_front()}, {24'h0, rx_out.data});
    chk("rx_frame_err", {31'h0, ferr}, {31'h0, rx_out.frame_err});
  endtask : wait_rx

  task automatic dut_tx(input logic [7:0] b, input int d, input logic one_wire);
    logic [7:0] got;
    logic ok;
    int n;
    exp_q.push_back(b);
    fork
      host.recv(d, one_wire, got, ok);
      begin
        reply_data = b;
        reply_valid = 1'b1;
        for (n = 0; n < 10; n++)
        begin
          @(negedge clk);
          if (reply_ready === 1'b1)
            break;
        end
        reply_valid = 1'b0;
        chk("reply_ready", 1, n < 10);
      end
    join
    chk("tx_byte", {24'h0, exp_q.pop_front()}, {24'h0, got});
    chk("tx_stop", 1, {31'h0, ok});
    // let the stop bit run out so the line is seen released, not mid-frame
    repeat (d) @(negedge clk);
    chk("line_idle", 1, {31'h0, mode_line});
    chk("tx_idle", 1, {31'h0, tx_pin});
    if (n == 10 || !ok)
      close_out();
  endtask : dut_tx

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    reset_n = 1'b0;
    rate_sel = 2'h0;
    rate_load = 1'b0;
    reply_valid = 1'b0;
    reply_data = 8'h00;
    n_mismatch = 0;
    checks = 0;
    seed = 32'd65002;
    do_reset(1'b0);
    chk("normal_fast_clock", 0, {31'h0, fast_clock_select});
    reply_valid = 1'b1;
    repeat (20)
    begin
      @(negedge clk);
      chk("refused_ready", 0, {31'h0, reply_ready});
      chk("idle_tx", 1, {31'h0, tx_pin});
    end
    reply_valid = 1'b0;
    $display("test normal_mode done");
    do_reset(1'b1);
    chk("fast_clock", 1, {31'h0, fast_clock_select});
    repeat (INIT_SIM + 20) @(negedge clk);
    chk("init_timeout", 1, {31'h0, init_timeout});
    for (int r = 0; r < 4; r++)
    begin
      rate_sel = r[1:0];
      rate_load = 1'b1;
      @(negedge clk);
      rate_load = 1'b0;
      div = CLK_HZ / RATES[r];
      v = xorshift();
      exp_q.push_back(v[7:0]);
      fork
        host.send(v[7:0], div, 1'b1, r[0]);
        wait_rx(div, 1'b0);
      join
      v = xorshift();
      dut_tx(v[7:0], div, r[1]);
      chk("prog_kept", 1, {31'h0, prog_mode});
      chk("port_oe", 0, {31'h0, sp_oe});
      chk("port_out", 0, {31'h0, sp_out});
      $display("test rate %0d done", r);
    end
    v = xorshift();
    exp_q.push_back(v[7:0]);
    fork
      host.send(v[7:0], div, 1'b0, 1'b1);
      wait_rx(div, 1'b1);
    join
    $display("test frame_error done");
    close_out();
  end
endmodule : test_serial_flash_program_entry

`default_nettype wire
